// File: core/ssma_adapter.sv
// ssma_adapter: byte-oriented synchronous serial adapter between a cpu
// command port and an external modem with its own bit clocks.
// assumes command strobes come from logic on CLOCK_I; modem pins are async.
//
// Functional notes
// - commands other than select act only while the adapter is selected
// - stop aborts activity, clears rx-available, error, break, dtr, rts
// - stop sets the transmit-needed flag
// - status byte: avail, need, error, cts, 0, dcd, dsr, 0
// - error bit stays high until the next character is received
// - dcd and dsr status follow the modem lines, never latched
// - read-data returns the received byte and clears rx-available
// - modem byte: bit 3 break, bit 1 dtr, bit 0 rts
// - pointer 80 tx sync, 40 line format, 20 rx sync, 10 tx data
// - register write lands in the register last chosen by the pointer
// - transmit sync register holds the sync and idle character
// - line format: bit 7 even parity, bit 6 no parity, bits 5:4 length
// - receiver finds character sync by matching the rx sync character
// - tx data write clears transmit-needed until the character is taken
// - receive interrupt request equals rx-available
// - transmit interrupt request equals transmit-needed
// - transmit and receive run at once, full duplex, up to 50,000 bps
`include "ssma_defines.svh"
`default_nettype none

module ssma_adapter
  import ssma_pkg::*;
#(
  parameter int CLK_MHZ  = `SSMA_CLK_MHZ,
  parameter int RX_DEPTH = 2
) (
  // clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       RST_I,
  // cpu command port
  input  wire logic       CMD_STB_I,
  input  wire ssma_cmd_t  CMD_CODE_I,
  input  wire logic [7:0] CMD_DATA_I,
  output logic      [7:0] RD_DATA_O,
  output logic            RD_VALID_O,
  output logic            SELECTED_O,
  // interrupt requests
  output logic            IRQ_RX_O,
  output logic            IRQ_TX_O,
  // modem lines
  output logic            TXD_O,
  output logic            RTS_O,
  output logic            DTR_O,
  input  wire logic       RXD_I,
  input  wire logic       CTS_I,
  input  wire logic       DSR_I,
  input  wire logic       DCD_I,
  input  wire logic       TXC_I,
  input  wire logic       RXC_I
);
  // ========================================================================
  // rate check: the modem clocks must be slow enough to find their edges
  localparam int MIN_BIT_CYC = (`SSMA_MIN_BIT_NS * CLK_MHZ) / 1000;
  if (MIN_BIT_CYC < 4) $error("ssma_adapter: clock too slow for link rate");

  // ========================================================================
  // pin synchronisers and clock edge detection
  logic [5:0] pins_s;
  logic       txc_d_r;
  logic       rxc_d_r;

  ssma_sync #(.WIDTH(6)) u_sync (
    .clk_i (CLOCK_I),
    .rst_i (RST_I),
    .d_i   ({RXC_I, TXC_I, RXD_I, CTS_I, DCD_I, DSR_I}),
    .q_o   (pins_s)
  );

  wire rxc_s = pins_s[5];
  wire txc_s = pins_s[4];
  wire rxd_s = pins_s[3];
  wire cts_s = pins_s[2];
  wire dcd_s = pins_s[1];
  wire dsr_s = pins_s[0];

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      txc_d_r <= 1'b0;
      rxc_d_r <= 1'b0;
    end else begin
      txc_d_r <= txc_s;
      rxc_d_r <= rxc_s;
    end
  end

  // data leaves on the falling tx clock so the modem samples it mid-bit
  wire tx_shift_en  = txc_d_r && !txc_s;
  wire rx_sample_en = !rxc_d_r && rxc_s;

  // ========================================================================
  // helpers
  function automatic logic [7:0] char_mask(input logic [3:0] n);
    char_mask = 8'hff >> (4'd8 - n);
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic even);
    par_bit = even ? ^d : ~^d;
  endfunction

  function automatic logic ptr_is(input logic [7:0] p, input logic [7:0] code);
    ptr_is = p == code;
  endfunction

  // ========================================================================
  // registers
  logic       sel_r;
  logic [7:0] ptr_r;
  logic [7:0] txsync_r;
  logic [7:0] rxsync_r;
  logic [7:0] fmt_r;
  logic [7:0] hold_r;
  logic       hold_full_r;
  logic       tx_need_r;
  logic       rx_avail_r;
  logic       err_r;
  logic [7:0] rx_byte_r;
  logic       brk_r;
  logic       dtr_r;
  logic       rts_r;
  logic [7:0] rd_data_r;
  logic       rd_valid_r;

  // ========================================================================
  // command decode
  wire cmd_ok    = CMD_STB_I && sel_r;
  wire do_select = CMD_STB_I && CMD_CODE_I == CMD_SELECT;
  wire do_stop   = cmd_ok && CMD_CODE_I == CMD_STOP;
  wire do_rd_st  = cmd_ok && CMD_CODE_I == CMD_READ_STATUS;
  wire do_rd_rx  = cmd_ok && CMD_CODE_I == CMD_READ_RX;
  wire do_modem  = cmd_ok && CMD_CODE_I == CMD_WRITE_MODEM;
  wire do_ptr    = cmd_ok && CMD_CODE_I == CMD_SET_POINTER;
  wire do_wreg   = cmd_ok && CMD_CODE_I == CMD_WRITE_REG;
  wire wr_txsync = do_wreg && ptr_is(ptr_r, `SSMA_PTR_TX_SYNC);
  wire wr_fmt    = do_wreg && ptr_is(ptr_r, `SSMA_PTR_LINE_FMT);
  wire wr_rxsync = do_wreg && ptr_is(ptr_r, `SSMA_PTR_RX_SYNC);
  wire wr_txdata = do_wreg && ptr_is(ptr_r, `SSMA_PTR_TX_DATA);

  // line format fields
  wire [3:0] nbits  = `SSMA_MIN_DATA_BITS +
                      {2'b00, fmt_r[`SSMA_LF_LEN_HI:`SSMA_LF_LEN_LO]};
  wire       par_en = !fmt_r[`SSMA_LF_NO_PARITY];
  wire       par_ev = fmt_r[`SSMA_LF_EVEN];
  wire [3:0] flen   = nbits + {3'b000, par_en};
  wire [7:0] mask   = char_mask(nbits);

  wire [7:0] status = {rx_avail_r, tx_need_r, err_r, cts_s, 1'b0,
                       dcd_s, dsr_s, 1'b0};

  // ========================================================================
  // select, pointer, configuration and modem control
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      sel_r <= 1'b0;
    end else if (do_select) begin
      sel_r <= CMD_DATA_I == `SSMA_SELECT_CODE;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ptr_r    <= 8'h00;
      txsync_r <= `SSMA_SYNC_RST;
      rxsync_r <= `SSMA_SYNC_RST;
      fmt_r    <= `SSMA_LINE_FMT_RST;
    end else begin
      if (do_ptr) ptr_r <= CMD_DATA_I;
      if (wr_txsync) txsync_r <= CMD_DATA_I;
      if (wr_rxsync) rxsync_r <= CMD_DATA_I;
      if (wr_fmt) fmt_r <= CMD_DATA_I;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      brk_r <= 1'b0;
      dtr_r <= 1'b0;
      rts_r <= 1'b0;
    end else if (do_stop) begin
      brk_r <= 1'b0;
      dtr_r <= 1'b0;
      rts_r <= 1'b0;
    end else if (do_modem) begin
      brk_r <= CMD_DATA_I[`SSMA_MC_BREAK];
      dtr_r <= CMD_DATA_I[`SSMA_MC_DTR];
      rts_r <= CMD_DATA_I[`SSMA_MC_RTS];
    end
  end

  // ========================================================================
  // transmitter; the shifter runs beside the receiver, full duplex
  logic [3:0] tx_cnt_r;
  logic [8:0] tx_sr_r;
  logic       tx_bit_r;
  logic       txd_r;

  wire       tx_load   = tx_shift_en && tx_cnt_r == 4'd0;
  wire       load_data = tx_load && hold_full_r;
  wire [7:0] tx_char   = (hold_full_r ? hold_r : txsync_r) & mask;
  wire [8:0] tx_frame  = {1'b0, tx_char} |
                         (9'(par_en && par_bit(tx_char, par_ev)) << nbits);

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_cnt_r <= 4'd0;
      tx_sr_r  <= 9'h000;
      tx_bit_r <= 1'b1;
    end else if (do_stop) begin
      tx_cnt_r <= 4'd0;
      tx_bit_r <= 1'b1;
    end else if (tx_load) begin
      tx_bit_r <= tx_frame[0];
      tx_sr_r  <= tx_frame >> 1;
      tx_cnt_r <= flen - 4'd1;
    end else if (tx_shift_en) begin
      tx_bit_r <= tx_sr_r[0];
      tx_sr_r  <= tx_sr_r >> 1;
      tx_cnt_r <= tx_cnt_r - 4'd1;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      txd_r <= 1'b1;
    end else begin
      txd_r <= brk_r ? 1'b0 : tx_bit_r;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      hold_r      <= 8'h00;
      hold_full_r <= 1'b0;
      tx_need_r   <= 1'b1;
    end else if (do_stop) begin
      hold_full_r <= 1'b0;
      tx_need_r   <= 1'b1;
    end else begin
      if (wr_txdata) begin
        hold_r      <= CMD_DATA_I;
        hold_full_r <= 1'b1;
      end else if (load_data) begin
        hold_full_r <= 1'b0;
      end
      // a take in the same cycle as a write still raises the request
      if (load_data) tx_need_r <= 1'b1;
      else if (wr_txdata) tx_need_r <= 1'b0;
    end
  end

  // ========================================================================
  // receiver: hunt for sync, then frame characters of the set length
  ssma_rx_st_t rx_st_r;
  logic [7:0]  rx_sr_r;
  logic [3:0]  rx_cnt_r;

  wire       rx_shift  = rx_st_r == RX_HUNT || rx_cnt_r < nbits;
  wire [7:0] rx_sr_nxt = rx_shift ? {rxd_s, rx_sr_r[7:1]} : rx_sr_r;
  wire [7:0] rx_char   = (rx_sr_nxt >> (4'd8 - nbits)) & mask;
  wire       sync_hit  = rx_char == (rxsync_r & mask);
  wire       rx_last   = rx_cnt_r == flen - 4'd1;
  wire       rx_perr   = par_en && rxd_s != par_bit(rx_char, par_ev);
  wire       rx_done   = rx_sample_en && rx_st_r == RX_DATA && rx_last;
  wire       rx_push   = rx_done && !sync_hit;
  wire       buf_ready;
  wire       buf_valid;
  wire [8:0] buf_data;
  wire       overrun   = rx_push && !buf_ready;
  wire       pop       = buf_valid && !rx_avail_r;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_st_r  <= RX_HUNT;
      rx_sr_r  <= 8'h00;
      rx_cnt_r <= 4'd0;
    end else if (do_stop) begin
      rx_st_r  <= RX_HUNT;
      rx_cnt_r <= 4'd0;
    end else if (rx_sample_en) begin
      rx_sr_r <= rx_sr_nxt;
      case (rx_st_r)
        RX_HUNT: begin
          if (sync_hit) rx_st_r <= RX_DATA;
          // a hit ends on the last data bit; with parity on, the sync's own
          // parity bit follows and is framed as a dropped sync character
          rx_cnt_r <= (sync_hit && par_en) ? nbits : 4'd0;
        end
        RX_DATA: begin
          rx_cnt_r <= rx_last ? 4'd0 : rx_cnt_r + 4'd1;
        end
        default: begin
          rx_st_r <= RX_HUNT;
        end
      endcase
    end
  end

  // sync characters seen in framed mode are idle fill and are dropped
  ssma_buf2 #(.WIDTH(9), .DEPTH(RX_DEPTH)) u_rxbuf (
    .clk_i       (CLOCK_I),
    .rst_i       (RST_I),
    .flush_i     (do_stop),
    .in_valid_i  (rx_push),
    .in_data_i   ({rx_perr, rx_char}),
    .in_ready_o  (buf_ready),
    .out_valid_o (buf_valid),
    .out_data_o  (buf_data),
    .out_ready_i (!rx_avail_r)
  );

  // ========================================================================
  // host-visible receive byte, flags and read answers
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_byte_r  <= 8'h00;
      rx_avail_r <= 1'b0;
      err_r      <= 1'b0;
    end else if (do_stop) begin
      rx_avail_r <= 1'b0;
      err_r      <= 1'b0;
    end else begin
      if (pop) begin
        rx_byte_r  <= buf_data[7:0];
        rx_avail_r <= 1'b1;
      end else if (do_rd_rx) begin
        rx_avail_r <= 1'b0;
      end
      if (overrun) err_r <= 1'b1;
      else if (pop) err_r <= buf_data[8];
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= do_rd_st || do_rd_rx;
      if (do_rd_st) rd_data_r <= status;
      else if (do_rd_rx) rd_data_r <= rx_byte_r;
    end
  end

  // ========================================================================
  // outputs, each straight from a flop
  assign RD_DATA_O  = rd_data_r;
  assign RD_VALID_O = rd_valid_r;
  assign SELECTED_O = sel_r;
  assign IRQ_RX_O   = rx_avail_r;
  assign IRQ_TX_O   = tx_need_r;
  assign TXD_O      = txd_r;
  assign RTS_O      = rts_r;
  assign DTR_O      = dtr_r;

  // ========================================================================
  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  sequence s_stop_done;
    !rx_avail_r && !err_r && !brk_r && !dtr_r && !rts_r;
  endsequence
  // a slot may take the byte right after the write, so the second step only
  // asks that the request stands exactly when the holding register is empty
  sequence s_tx_filled;
    !tx_need_r ##1 IRQ_TX_O == !hold_full_r;
  endsequence

  property p_unselected;
    CMD_STB_I && !sel_r && CMD_CODE_I != CMD_SELECT |=> !RD_VALID_O;
  endproperty
  a_unselected: assert property (p_unselected) else $error("command taken unselected");

  property p_stop;
    do_stop |=> s_stop_done;
  endproperty
  a_stop: assert property (p_stop) else $error("stop left a flag or line set");

  property p_stop_need;
    do_stop |=> tx_need_r && IRQ_TX_O;
  endproperty
  a_stop_need: assert property (p_stop_need) else $error("stop did not raise tx need");

  property p_status;
    do_rd_st |=> RD_VALID_O && RD_DATA_O[3] == 1'b0 && RD_DATA_O[0] == 1'b0 &&
                 RD_DATA_O[7] == $past(rx_avail_r) && RD_DATA_O[4] == $past(cts_s);
  endproperty
  a_status: assert property (p_status) else $error("status byte misplaced");

  property p_lines;
    do_rd_st |=> RD_DATA_O[2] == $past(dcd_s) && RD_DATA_O[1] == $past(dsr_s);
  endproperty
  a_lines: assert property (p_lines) else $error("modem status not live");

  property p_err_hold;
    err_r && !pop && !do_stop |=> err_r;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error dropped early");

  property p_read_rx;
    do_rd_rx && rx_avail_r |=> !rx_avail_r && RD_DATA_O == $past(rx_byte_r);
  endproperty
  a_read_rx: assert property (p_read_rx) else $error("read data wrong");

  property p_break;
    brk_r [*2] |-> !TXD_O;
  endproperty
  a_break: assert property (p_break) else $error("break not forced");

  property p_fmt_write;
    wr_fmt |=> fmt_r == $past(CMD_DATA_I);
  endproperty
  a_fmt_write: assert property (p_fmt_write) else $error("pointer write missed");

  property p_hunt;
    rx_st_r == RX_HUNT && rx_sample_en && sync_hit && !do_stop |=> rx_st_r == RX_DATA;
  endproperty
  a_hunt: assert property (p_hunt) else $error("sync not detected");

  property p_tx_write;
    wr_txdata && !load_data && !do_stop |=> s_tx_filled;
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("tx need not cleared");

  property p_rx_irq;
    pop && !do_stop |=> IRQ_RX_O && {1'b0, rx_byte_r} == ($past(buf_data) & 9'h0ff);
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx request missing");

  property p_tx_irq;
    load_data && !do_stop |=> IRQ_TX_O;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx request missing");

  property p_idle;
    tx_load && !hold_full_r && !do_stop |=> tx_bit_r == $past(txsync_r[0]);
  endproperty
  a_idle: assert property (p_idle) else $error("idle character not sent");
endmodule

`default_nettype wire

// File: core/ssma_defines.svh
// ssma_defines.svh: offsets, field positions, reset values and timing counts
// for the synchronous modem adapter; included by bare name from core/
`ifndef SSMA_DEFINES_SVH
`define SSMA_DEFINES_SVH

// ==========================================================================
// command byte values
`define SSMA_SELECT_CODE     8'hf0
`define SSMA_PTR_TX_SYNC     8'h80
`define SSMA_PTR_LINE_FMT    8'h40
`define SSMA_PTR_RX_SYNC     8'h20
`define SSMA_PTR_TX_DATA     8'h10

// ==========================================================================
// line_status bit positions
`define SSMA_ST_RX_AVAIL     7
`define SSMA_ST_TX_NEED      6
`define SSMA_ST_ERROR        5
`define SSMA_ST_CTS          4
`define SSMA_ST_DCD          2
`define SSMA_ST_DSR          1

// ==========================================================================
// modem_control and line_format bit positions
`define SSMA_MC_BREAK        3
`define SSMA_MC_DTR          1
`define SSMA_MC_RTS          0
`define SSMA_LF_EVEN         7
`define SSMA_LF_NO_PARITY    6
`define SSMA_LF_LEN_HI       5
`define SSMA_LF_LEN_LO       4
`define SSMA_MIN_DATA_BITS   4'd5

// ==========================================================================
// reset values and timing
`define SSMA_LINE_FMT_RST    8'h70
`define SSMA_SYNC_RST        8'h16
`define SSMA_CLK_MHZ         100
`define SSMA_MAX_BPS         50000
`define SSMA_MIN_BIT_NS      20000

`endif

// File: core/ssma_pkg.sv
// ssma_pkg: types shared by the synchronous modem adapter files
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package ssma_pkg;
  // ========================================================================
  // host command kinds and receiver states
  typedef enum logic [2:0] {
    CMD_SELECT,
    CMD_STOP,
    CMD_READ_STATUS,
    CMD_READ_RX,
    CMD_WRITE_MODEM,
    CMD_SET_POINTER,
    CMD_WRITE_REG
  } ssma_cmd_t;

  typedef enum logic [1:0] {
    RX_HUNT,
    RX_DATA
  } ssma_rx_st_t;
endpackage

`default_nettype wire

// File: core/ssma_sync.sv
// ssma_sync: two-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is independent; no bus coherence is promised
`default_nettype none

module ssma_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // levels
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) $error("ssma_sync: WIDTH must be at least 1");

  // ========================================================================
  // one pair of flops per bit; the first is read only by the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        meta_r[i] <= 1'b0;
        q_o[i]    <= 1'b0;
      end else begin
        meta_r[i] <= d_i[i];
        q_o[i]    <= meta_r[i];
      end
    end
  end
endmodule

`default_nettype wire

// File: core/ssma_buf2.sv
// ssma_buf2: small valid/ready fifo, two entries by default
// assumes DEPTH a power of two; flush empties it in one cycle
`default_nettype none

module ssma_buf2 #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             flush_i,
  // filling side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // draining side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("ssma_buf2: bad DEPTH");

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_r != '0;
  assign out_data_o  = mem_r[rd_r];

  // ========================================================================
  // storage carries no reset: it is only read while counted valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (flush_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_r + AW'(push);
      rd_r  <= rd_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

`default_nettype wire

// File: verif/ssma_modem.sv
// ssma_modem: synchronous modem model giving line clocks and rx data
// assumes one instance in the bench; both clocks run free at 160 ns
`default_nettype none

module ssma_modem #(
  parameter logic [7:0] IDLE = 8'h16
) (
  // line clocks and data
  output logic      txc_o,
  output logic      rxc_o,
  output logic      rxd_o,
  // transmitted data from the adapter
  input  wire logic txd_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];
  logic [7:0] b;
  logic [7:0] idle = IDLE;
  logic [7:0] tx_sh;

  // ==========================================================================
  // clocks: a sync modem clocks whether or not data flows
  initial txc_o = 1'b0;
  always #80 txc_o = ~txc_o;

  task automatic send(input logic [7:0] v);
    q.push_back(v);
  endtask

  // tx data: sampled on the rising clock, the last eight bits kept lsb first
  always @(posedge txc_o) tx_sh <= {txd_i, tx_sh[7:1]};

  // ==========================================================================
  // rx data: lsb first, changed on falling clock; idle fill is the sync char
  initial begin
    rxc_o = 1'b0;
    rxd_o = 1'b1;
    #3;
    forever begin
      b = (q.size() != 0) ? q.pop_front() : idle;
      for (int i = 0; i < 8; i++) begin
        rxd_o = b[i];
        #80 rxc_o = 1'b1;
        #80 rxc_o = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// File: verif/sync_serial_modem_adapter_test.sv
// sync_serial_modem_adapter_test: self-checking bench for ssma_adapter
// assumes ssma_modem as far side; inputs change on the falling edge
`include "ssma_defines.svh"
`default_nettype none

module sync_serial_modem_adapter_test import ssma_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst, stb, rd_valid, sel, irq_rx, irq_tx, txd, rts, dtr;
  logic       cts, dsr, dcd, txc, rxc, rxd;
  ssma_cmd_t  code;
  logic [7:0] data, rd_data, m, v, d, t;
  logic [7:0] rxq[$];
  int         n_mismatch, n_tests, cyc;

  ssma_adapter ssma_adapter_i (.CLOCK_I(clk), .RST_I(rst), .CMD_STB_I(stb),
    .CMD_CODE_I(code), .CMD_DATA_I(data), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid),
    .SELECTED_O(sel), .IRQ_RX_O(irq_rx), .IRQ_TX_O(irq_tx), .TXD_O(txd), .RTS_O(rts),
    .DTR_O(dtr), .RXD_I(rxd), .CTS_I(cts), .DSR_I(dsr), .DCD_I(dcd), .TXC_I(txc),
    .RXC_I(rxc));
  ssma_modem ssma_modem_i (.txc_o(txc), .rxc_o(rxc), .rxd_o(rxd), .txd_i(txd));

  // ==========================================================================
  // clock, timeout and shared tasks
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cmd(input ssma_cmd_t c, input logic [7:0] b);
    @(negedge clk);
    stb = 1'b1;
    code = c;
    data = b;
    @(negedge clk);
    stb = 1'b0;
  endtask

  // the answer pulse lasts one cycle, so look each cycle for a few cycles
  task automatic rd(input ssma_cmd_t c, output logic [7:0] r);
    int n;
    n = 0;
    cmd(c, 8'h00);
    while (rd_valid !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    chk("rd_valid", rd_valid, 8'h01);
    r = rd_data;
    @(negedge clk);
    chk("rd_valid", rd_valid, 8'h00);
  endtask

  task automatic wait_irq(input bit rx);
    int n;
    n = 0;
    while ((rx ? irq_rx : irq_tx) !== 1'b1 && n < 800) begin
      @(negedge clk);
      n++;
    end
  endtask

  // write one tx byte, then watch the modem's last eight sampled bits for it
  task automatic tx_chk(input logic [7:0] c, input logic [7:0] want);
    int n;
    n = 0;
    chk("irq_tx", irq_tx, 8'h01);
    cmd(CMD_SET_POINTER, `SSMA_PTR_TX_DATA);
    cmd(CMD_WRITE_REG, c);
    chk("irq_tx", irq_tx, 8'h00);
    wait_irq(1'b0);
    chk("irq_tx", irq_tx, 8'h01);
    while (ssma_modem_i.tx_sh !== want && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("tx_char", ssma_modem_i.tx_sh, want);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    stb = 1'b0;
    code = CMD_SELECT;
    data = 8'h00;
    {cts, dsr, dcd} = 3'b000;
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(32'h9e8849d0));
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk("irq_tx", irq_tx, 8'h01);
    cmd(CMD_WRITE_MODEM, 8'h03);
    chk("rts", rts, 8'h00);
    cmd(CMD_SELECT, `SSMA_SELECT_CODE);
    chk("sel", sel, 8'h01);
    for (int i = 0; i < 6; i++) begin
      m = $urandom;
      {cts, dsr, dcd} = $urandom;
      cmd(CMD_WRITE_MODEM, m);
      chk("rts", rts, m[0]);
      chk("dtr", dtr, m[1]);
      rd(CMD_READ_STATUS, v);
      chk("status", v, {3'b010, cts, 1'b0, dcd, dsr, 1'b0});
    end
    cmd(CMD_WRITE_MODEM, 8'h08);
    repeat (3) @(negedge clk);
    chk("txd", txd, 8'h00);
    cmd(CMD_WRITE_MODEM, 8'h03);
    // a pointer outside the four targets must not reach the holding register
    cmd(CMD_SET_POINTER, 8'h30);
    cmd(CMD_WRITE_REG, 8'h5a);
    chk("irq_tx", irq_tx, 8'h01);
    for (int k = 0; k < 2; k++) begin
      d = $urandom;
      if (d == `SSMA_SYNC_RST) d = 8'h3c;
      rxq.push_back(d);
      ssma_modem_i.send(d);
      t = $urandom;
      tx_chk(t, t);
      wait_irq(1'b1);
      chk("irq_rx", irq_rx, 8'h01);
      if (k == 0) begin
        rd(CMD_READ_RX, v);
        chk("rx_byte", v, rxq.pop_front());
        chk("irq_rx", irq_rx, 8'h00);
      end
    end
    // 7 bits plus even parity keeps an 8-bit slot; idle gets its parity bit
    cmd(CMD_SET_POINTER, `SSMA_PTR_LINE_FMT);
    cmd(CMD_WRITE_REG, 8'ha0);
    ssma_modem_i.idle = 8'h96;
    cmd(CMD_STOP, 8'h00);
    chk("irq_rx", irq_rx, 8'h00);
    chk("modem", {rts, dtr}, 8'h00);
    chk("irq_tx", irq_tx, 8'h01);
    rd(CMD_READ_STATUS, v);
    chk("status", v & 8'he0, 8'h40);
    // receiver hunts again under parity; second character has bad parity
    for (int k = 0; k < 2; k++) begin
      d = $urandom;
      if (d[6:0] == 7'h16) d = 8'h3c;
      ssma_modem_i.send({^d[6:0] ^ k[0], d[6:0]});
      wait_irq(1'b1);
      chk("irq_rx", irq_rx, 8'h01);
      rd(CMD_READ_STATUS, v);
      chk("error", v[5], k[0]);
      rd(CMD_READ_RX, v);
      chk("rx_byte", v, d & 8'h7f);
    end
    rd(CMD_READ_STATUS, v);
    chk("error", v[5], 8'h01);
    t = $urandom;
    tx_chk(t, {^t[6:0], t[6:0]});
    cmd(CMD_SELECT, 8'h00);
    chk("sel", sel, 8'h00);
    end_of_test();
  end
endmodule

`default_nettype wire
